// ---- hw/bstap_top.sv ----
// Boundary-scan access port: scan registers, output latches and test-mode outputs.
`default_nettype none

module bstap_top #(
	parameter int BSR_W = bstap_pkg::BSR_LEN,
	parameter logic [bstap_pkg::ID_LEN-1:0] IDCODE = bstap_pkg::ID_CODE_DEFAULT
) (
	// System
	input wire logic clk,
	input wire logic reset,
	// Test access port
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// Device pins seen by the boundary cells
	input wire logic [BSR_W-1:0] pin_in,
	output logic [BSR_W-1:0] bsr_drive,
	output logic test_mode,
	// Normal-function output enables
	output logic [1:0] b_side_output_enable,
	output logic [1:0] a_side_output_enable_n,
	// Test operation
	output logic test_op_active,
	output logic [bstap_pkg::BCR_LEN-1:0] test_op_code,
	output logic parallel_signature_op,
	output logic [bstap_pkg::IR_LEN-1:0] instruction
);
	import bstap_pkg::*;

	// Reset image of the boundary chain: enable cells safe, the rest cleared
	localparam logic [BSR_W-1:0] BSR_SAFE = {BSR_B_SIDE_OUTPUT_ENABLE_RST, BSR_A_SIDE_OUTPUT_ENABLE_N_RST, {BSR_A_SIDE_OUTPUT_ENABLE_N_LO{1'h0}}};

	////////////////////////////////////////////////////////////////////////////////

	// The enable cells sit at fixed positions, so the chain must be exactly 48 cells long
	if (BSR_W != BSR_LEN) begin : g_bad_width
		$error("bstap_top: boundary chain width must be 48");
	end

	// Bit 0 set keeps the identity word apart from a bypass bit on the same path
	if (IDCODE[0] != 1'h1) begin : g_bad_idcode
		$error("bstap_top: identity code bit 0 must be set");
	end

	// Edge pulses and synced levels shared by the controller and the scan core
	bstap_if lnk();

	bstap_sync bstap_sync_inst (
		.clk(clk),
		.reset(reset),
		.tck_pin(tck),
		.tms_pin(tms),
		.tdi_pin(tdi),
		.lnk(lnk)
	);

	bstap_fsm bstap_fsm_inst (
		.clk(clk),
		.reset(reset),
		.lnk(lnk)
	);

	////////////////////////////////////////////////////////////////////////////////

	logic [BSR_W-1:0] pin_s1_ff;
	logic [BSR_W-1:0] pin_s2_ff;

	// Restart at the pull levels so no enable turns on while the stages refill
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_s1_ff <= BSR_SAFE;
			pin_s2_ff <= BSR_SAFE;
		end else begin
			pin_s1_ff <= pin_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// State decode; the qualifiers built from it below are single-clock pulses
	wire rise = lnk.tck_rise;
	wire fall = lnk.tck_fall;
	wire in_tlr = lnk.state == ST_TLR;
	wire in_rti = lnk.state == ST_RTI;
	wire in_cap_dr = lnk.state == ST_CAP_DR;
	wire in_sh_dr = lnk.state == ST_SH_DR;
	wire in_upd_dr = lnk.state == ST_UPD_DR;
	wire in_cap_ir = lnk.state == ST_CAP_IR;
	wire in_sh_ir = lnk.state == ST_SH_IR;
	wire in_upd_ir = lnk.state == ST_UPD_IR;

	// Register latches and shift stages
	logic [IR_LEN-1:0] ir_sh_ff;
	logic [IR_LEN-1:0] ir_ff;
	logic [BSR_W-1:0] bsr_sh_ff;
	logic [BSR_W-1:0] bsr_lat_ff;
	logic [BCR_LEN-1:0] bcr_sh_ff;
	logic [BCR_LEN-1:0] bcr_lat_ff;
	logic [ID_LEN-1:0] id_sh_ff;
	logic byp_ff;
	logic run_ff;

	// Instruction decode: unknown codes fall back to bypass
	wire op_extest = ir_ff == IR_EXTEST;
	wire op_sample = ir_ff == IR_SAMPLE;
	wire op_runtest = ir_ff == IR_RUNTEST;
	wire op_idcode = ir_ff == IR_IDCODE;
	wire op_bcrscan = ir_ff == IR_BCRSCAN;
	wire sel_bsr = op_extest | op_sample | op_runtest;
	wire sel_id = op_idcode;
	wire sel_bcr = op_bcrscan;
	wire sel_byp = ~(sel_bsr | sel_id | sel_bcr);
	// Test mode inhibits the normal enables; sample and bypass leave them alone
	wire is_test = op_extest | op_runtest;

	// Only the working register of the path moves; others keep their contents
	wire cap_dr = rise & in_cap_dr;
	wire sh_dr = rise & in_sh_dr;
	wire upd_dr = fall & in_upd_dr;
	wire tlr_fall = fall & in_tlr;
	wire run_psa = rise & in_rti & run_ff & (bcr_lat_ff == BCR_PSA);

	// Signature step: rotate and fold in the sampled inputs
	wire [BSR_W-1:0] bsr_psa = {bsr_sh_ff[0], bsr_sh_ff[BSR_W-1:1]} ^ pin_s2_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction register
	// Capture and shift share one stage; the active instruction waits in its own latch

	always_ff @(posedge clk) begin
		if (reset) begin
			ir_sh_ff <= IR_RESET;
		end else if (rise & in_cap_ir) begin
			ir_sh_ff <= IR_CAPTURE;
		end else if (rise & in_sh_ir) begin
			ir_sh_ff <= {lnk.tdi, ir_sh_ff[IR_LEN-1:1]};
		end
	end

	always_ff @(posedge clk) begin
		if (reset | tlr_fall) begin
			ir_ff <= IR_RESET;
		end else if (fall & in_upd_ir) begin
			ir_ff <= ir_sh_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Boundary-scan register

	always_ff @(posedge clk) begin
		if (reset | tlr_fall) begin
			bsr_sh_ff <= '0;
			bsr_sh_ff[BSR_B_SIDE_OUTPUT_ENABLE_HI:BSR_B_SIDE_OUTPUT_ENABLE_LO] <= BSR_B_SIDE_OUTPUT_ENABLE_RST;
			bsr_sh_ff[BSR_A_SIDE_OUTPUT_ENABLE_N_HI:BSR_A_SIDE_OUTPUT_ENABLE_N_LO] <= BSR_A_SIDE_OUTPUT_ENABLE_N_RST;
		end else if (cap_dr & sel_bsr) begin
			bsr_sh_ff <= pin_s2_ff;
		end else if (sh_dr & sel_bsr) begin
			bsr_sh_ff <= {lnk.tdi, bsr_sh_ff[BSR_W-1:1]};
		end else if (run_psa) begin
			bsr_sh_ff <= bsr_psa;
		end
	end

	always_ff @(posedge clk) begin
		if (reset | tlr_fall) begin
			bsr_lat_ff <= '0;
			bsr_lat_ff[BSR_B_SIDE_OUTPUT_ENABLE_HI:BSR_B_SIDE_OUTPUT_ENABLE_LO] <= BSR_B_SIDE_OUTPUT_ENABLE_RST;
			bsr_lat_ff[BSR_A_SIDE_OUTPUT_ENABLE_N_HI:BSR_A_SIDE_OUTPUT_ENABLE_N_LO] <= BSR_A_SIDE_OUTPUT_ENABLE_N_RST;
		end else if (upd_dr & sel_bsr) begin
			bsr_lat_ff <= bsr_sh_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Boundary-control, bypass and identification registers

	always_ff @(posedge clk) begin
		if (reset | tlr_fall) begin
			bcr_sh_ff <= BCR_RESET;
		end else if (cap_dr & sel_bcr) begin
			bcr_sh_ff <= bcr_lat_ff;
		end else if (sh_dr & sel_bcr) begin
			bcr_sh_ff <= {lnk.tdi, bcr_sh_ff[BCR_LEN-1:1]};
		end
	end

	always_ff @(posedge clk) begin
		if (reset | tlr_fall) begin
			bcr_lat_ff <= BCR_RESET;
		end else if (upd_dr & sel_bcr) begin
			bcr_lat_ff <= bcr_sh_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			byp_ff <= BYP_CAPTURE;
		end else if (cap_dr & sel_byp) begin
			byp_ff <= BYP_CAPTURE;
		end else if (sh_dr & sel_byp) begin
			byp_ff <= lnk.tdi;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			id_sh_ff <= IDCODE;
		end else if (cap_dr & sel_id) begin
			id_sh_ff <= IDCODE;
		end else if (sh_dr & sel_id) begin
			id_sh_ff <= {lnk.tdi, id_sh_ff[ID_LEN-1:1]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial output

	wire dr_lsb = sel_bsr ? bsr_sh_ff[0] :
		sel_id ? id_sh_ff[0] :
		sel_bcr ? bcr_sh_ff[0] : byp_ff;
	wire nxt_tdo = in_sh_ir ? ir_sh_ff[0] : dr_lsb;
	// Outside the shift states tdo still follows the selected low bit on each fall; only tdo_oe marks it released
	wire nxt_tdo_oe = in_sh_dr | in_sh_ir;

	logic tdo_ff;
	logic tdo_oe_ff;

	// Launch on the fall so the master samples a settled bit at the rise
	always_ff @(posedge clk) begin
		if (reset) begin
			tdo_ff <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end else if (fall) begin
			tdo_ff <= nxt_tdo;
			tdo_oe_ff <= nxt_tdo_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Test operation and mode outputs

	// Starts and stops on a fall, so a signature step never sees half a cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			run_ff <= 1'b0;
		end else if (fall) begin
			run_ff <= in_rti & op_runtest;
		end
	end

	wire [1:0] nxt_b_oe = is_test ? bsr_lat_ff[BSR_B_SIDE_OUTPUT_ENABLE_HI:BSR_B_SIDE_OUTPUT_ENABLE_LO] :
		pin_s2_ff[BSR_B_SIDE_OUTPUT_ENABLE_HI:BSR_B_SIDE_OUTPUT_ENABLE_LO];
	wire [1:0] nxt_a_oe_n = is_test ? bsr_lat_ff[BSR_A_SIDE_OUTPUT_ENABLE_N_HI:BSR_A_SIDE_OUTPUT_ENABLE_N_LO] :
		pin_s2_ff[BSR_A_SIDE_OUTPUT_ENABLE_N_HI:BSR_A_SIDE_OUTPUT_ENABLE_N_LO];
	// Signature flag trails the run flag by one clock, like the latch outputs
	wire nxt_psa = run_ff & (bcr_lat_ff == BCR_PSA);

	logic test_mode_ff;
	logic [1:0] b_oe_ff;
	logic [1:0] a_oe_n_ff;
	logic [BSR_W-1:0] drive_ff;
	logic [BCR_LEN-1:0] op_code_ff;
	logic psa_ff;
	logic [IR_LEN-1:0] instr_ff;

	// Safe reset levels: B-side off (low), A-side off (high)
	always_ff @(posedge clk) begin
		if (reset) begin
			test_mode_ff <= 1'b0;
			b_oe_ff <= BSR_B_SIDE_OUTPUT_ENABLE_RST;
			a_oe_n_ff <= BSR_A_SIDE_OUTPUT_ENABLE_N_RST;
			drive_ff <= BSR_SAFE;
			op_code_ff <= BCR_RESET;
			psa_ff <= 1'b0;
			instr_ff <= IR_RESET;
		end else begin
			test_mode_ff <= is_test;
			b_oe_ff <= nxt_b_oe;
			a_oe_n_ff <= nxt_a_oe_n;
			drive_ff <= bsr_lat_ff;
			op_code_ff <= bcr_lat_ff;
			psa_ff <= nxt_psa;
			instr_ff <= ir_ff;
		end
	end

	assign tdo = tdo_ff;
	assign tdo_oe = tdo_oe_ff;
	assign bsr_drive = drive_ff;
	assign test_mode = test_mode_ff;
	assign b_side_output_enable = b_oe_ff;
	assign a_side_output_enable_n = a_oe_n_ff;
	assign test_op_active = run_ff;
	assign test_op_code = op_code_ff;
	assign parallel_signature_op = psa_ff;
	assign instruction = instr_ff;
endmodule

`default_nettype wire

// ---- shared/bstap_pkg.sv ----
// Constants, state codes and instruction codes of the boundary-scan access port.
`default_nettype none

package bstap_pkg;

	localparam int IR_LEN = 8;
	localparam int BSR_LEN = 48;
	localparam int BCR_LEN = 3;
	localparam int ID_LEN = 32;

	localparam logic [IR_LEN-1:0] IR_RESET = 8'h81;
	localparam logic [IR_LEN-1:0] IR_CAPTURE = 8'h81;
	localparam logic [IR_LEN-1:0] IR_EXTEST = 8'h00;
	localparam logic [IR_LEN-1:0] IR_IDCODE = 8'h81;
	localparam logic [IR_LEN-1:0] IR_SAMPLE = 8'h82;
	localparam logic [IR_LEN-1:0] IR_BCRSCAN = 8'h87;
	localparam logic [IR_LEN-1:0] IR_RUNTEST = 8'h09;
	localparam logic [IR_LEN-1:0] IR_BYPASS = 8'hff;

	localparam logic [BCR_LEN-1:0] BCR_RESET = 3'h2;
	localparam logic [BCR_LEN-1:0] BCR_PSA = 3'h2;

	// Output-enable cells and their safe reset levels
	localparam int BSR_B_SIDE_OUTPUT_ENABLE_HI = 47;
	localparam int BSR_B_SIDE_OUTPUT_ENABLE_LO = 46;
	localparam int BSR_A_SIDE_OUTPUT_ENABLE_N_HI = 45;
	localparam int BSR_A_SIDE_OUTPUT_ENABLE_N_LO = 44;
	localparam logic [1:0] BSR_B_SIDE_OUTPUT_ENABLE_RST = 2'h0;
	localparam logic [1:0] BSR_A_SIDE_OUTPUT_ENABLE_N_RST = 2'h3;

	localparam logic BYP_CAPTURE = 1'b0;

	// Arbitrary identity value; bit 0 set as the scan standard expects
	localparam logic [ID_LEN-1:0] ID_CODE_DEFAULT = 32'h0a5a_5001;

	typedef enum logic [15:0] {
		ST_TLR = 16'h0001,
		ST_RTI = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PAU_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PAU_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} bstap_state_t;

endpackage

`default_nettype wire

// ---- shared/bstap_if.sv ----
// Link between the pin sampler, the state machine and the scan core.
`default_nettype none

interface bstap_if;
	logic tck_rise;
	logic tck_fall;
	logic tms;
	logic tdi;
	bstap_pkg::bstap_state_t state;

	modport sampler (output tck_rise, output tck_fall, output tms, output tdi);
	modport fsm (input tck_rise, input tms, output state);
	modport core (input tck_rise, input tck_fall, input tms, input tdi, input state);
endinterface

`default_nettype wire

// ---- hw/bstap_sync.sv ----
// Pin synchroniser and test clock edge finder.
`default_nettype none

module bstap_sync (
	// System
	input wire logic clk,
	input wire logic reset,
	// Test pins
	input wire logic tck_pin,
	input wire logic tms_pin,
	input wire logic tdi_pin,
	// Edges and sampled levels
	bstap_if.sampler lnk
);
	import bstap_pkg::*;

	logic [2:0] s1_ff;
	logic [2:0] s2_ff;
	logic tck_d_ff;
	logic rise_ff;
	logic fall_ff;
	logic tms_ff;
	logic tdi_ff;

	wire nxt_rise = s2_ff[0] & ~tck_d_ff;
	wire nxt_fall = ~s2_ff[0] & tck_d_ff;

	// Pins default high when idle, so reset to high avoids a false edge
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_ff <= 3'h7;
			s2_ff <= 3'h7;
		end else begin
			s1_ff <= {tdi_pin, tms_pin, tck_pin};
			s2_ff <= s1_ff;
		end
	end

	// Levels are delayed with the edge so TMS and TDI match the rise
	always_ff @(posedge clk) begin
		if (reset) begin
			tck_d_ff <= 1'b1;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
			tms_ff <= 1'b1;
			tdi_ff <= 1'b1;
		end else begin
			tck_d_ff <= s2_ff[0];
			rise_ff <= nxt_rise;
			fall_ff <= nxt_fall;
			tms_ff <= s2_ff[1];
			tdi_ff <= s2_ff[2];
		end
	end

	assign lnk.tck_rise = rise_ff;
	assign lnk.tck_fall = fall_ff;
	assign lnk.tms = tms_ff;
	assign lnk.tdi = tdi_ff;
endmodule

`default_nettype wire

// ---- hw/bstap_fsm.sv ----
// Sixteen-state test access port controller.
`default_nettype none

module bstap_fsm (
	// System
	input wire logic clk,
	input wire logic reset,
	// Edges in, state out
	bstap_if.fsm lnk
);
	import bstap_pkg::*;

	bstap_state_t state_ff;
	bstap_state_t nxt_state;

	// Every branch with TMS high heads towards reset within five steps
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_TLR: nxt_state = lnk.tms ? ST_TLR : ST_RTI;
			ST_RTI: nxt_state = lnk.tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: nxt_state = lnk.tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: nxt_state = lnk.tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: nxt_state = lnk.tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: nxt_state = lnk.tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: nxt_state = lnk.tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: nxt_state = lnk.tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: nxt_state = lnk.tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: nxt_state = lnk.tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: nxt_state = lnk.tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: nxt_state = lnk.tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: nxt_state = lnk.tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: nxt_state = lnk.tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: nxt_state = lnk.tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: nxt_state = lnk.tms ? ST_SEL_DR : ST_RTI;
			default: nxt_state = ST_TLR;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= ST_TLR;
		end else if (lnk.tck_rise) begin
			state_ff <= nxt_state;
		end
	end

	assign lnk.state = state_ff;
endmodule

`default_nettype wire

// ---- sim/bstap_checker.sv ----
// Port-level property checker for the boundary-scan access port.
`default_nettype none

module bstap_checker #(
	parameter int BSR_W = bstap_pkg::BSR_LEN
) (
	// System
	input wire logic clk,
	input wire logic reset,
	// Test access port
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdo_oe,
	// Boundary and normal outputs
	input wire logic [BSR_W-1:0] pin_in,
	input wire logic [BSR_W-1:0] bsr_drive,
	input wire logic test_mode,
	input wire logic [1:0] b_side_output_enable,
	input wire logic [1:0] a_side_output_enable_n,
	input wire logic test_op_active,
	input wire logic [bstap_pkg::BCR_LEN-1:0] test_op_code,
	input wire logic parallel_signature_op,
	input wire logic [bstap_pkg::IR_LEN-1:0] instruction
);
	import bstap_pkg::*;
	logic [2:0] age_ff;
	wire logic [1:0] pin_b = pin_in[BSR_B_SIDE_OUTPUT_ENABLE_HI:BSR_B_SIDE_OUTPUT_ENABLE_LO];
	wire logic [1:0] pin_a = pin_in[BSR_A_SIDE_OUTPUT_ENABLE_N_HI:BSR_A_SIDE_OUTPUT_ENABLE_N_LO];

	// Pin stages restart at the safe levels after reset, so the pass-through is judged later
	always_ff @(posedge clk) begin
		if (reset)
			age_ff <= 3'h0;
		else if (age_ff != 3'h7)
			age_ff <= age_ff + 3'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////
	property p_rst;
		$fell(reset) |-> instruction == IR_RESET && test_op_code == BCR_RESET && !tdo_oe
			&& bsr_drive[47:44] == {BSR_B_SIDE_OUTPUT_ENABLE_RST, BSR_A_SIDE_OUTPUT_ENABLE_N_RST};
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_quiet;
		tck |-> $stable(tdo) && $stable(tdo_oe);
	endproperty
	a_quiet: assert property (p_quiet) else $error("tdo moved with clock high");
	property p_norm_b;
		age_ff == 3'h7 && !test_mode && !$past(test_mode, 4)
			|-> b_side_output_enable == $past(pin_b, 3);
	endproperty
	a_norm_b: assert property (p_norm_b) else $error("b enable not passed");
	property p_norm_a;
		age_ff == 3'h7 && !test_mode && !$past(test_mode, 4)
			|-> a_side_output_enable_n == $past(pin_a, 3);
	endproperty
	a_norm_a: assert property (p_norm_a) else $error("a enable not passed");
	property p_test_oe;
		test_mode && $past(test_mode) && $stable(bsr_drive)
			|-> b_side_output_enable == bsr_drive[47:46]
			&& a_side_output_enable_n == bsr_drive[45:44];
	endproperty
	a_test_oe: assert property (p_test_oe) else $error("test enables wrong");
	property p_ir;
		$changed(instruction) |-> !$past(tck) && !tdo_oe;
	endproperty
	a_ir: assert property (p_ir) else $error("instruction moved off fall");
	property p_lat;
		$changed(bsr_drive) || $changed(test_op_code) |-> !$past(tck) && !tdo_oe;
	endproperty
	a_lat: assert property (p_lat) else $error("latch moved off fall");
	property p_op;
		test_op_active |-> instruction == IR_RUNTEST && test_mode && !tdo_oe;
	endproperty
	a_op: assert property (p_op) else $error("test op outside idle");
	property p_psa;
		parallel_signature_op |-> test_op_code == BCR_PSA && instruction == IR_RUNTEST;
	endproperty
	a_psa: assert property (p_psa) else $error("signature op wrong");
endmodule

bind bstap_top bstap_checker #(.BSR_W(BSR_W)) bstap_checker_inst (
	.clk, .reset, .tck, .tdo, .tdo_oe, .pin_in, .bsr_drive, .test_mode,
	.b_side_output_enable, .a_side_output_enable_n, .test_op_active,
	.test_op_code, .parallel_signature_op, .instruction
);

`default_nettype wire

// ---- sim/bstap_master.sv ----
// Model of the external scan controller that drives the test pins.
`default_nettype none

module bstap_master (
	// System
	input wire logic clk,
	// Test pins
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input wire logic tdo,
	// Scan results
	output var logic done,
	output var logic [63:0] dout
);
	timeunit 1ns;
	timeprecision 1ps;

	// Clock parks high between frames; mode and data rest at their pull-up level
	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b1;
		done = 1'b0;
		dout = '0;
	end

	// One test clock of ten system clocks
	task automatic step(input logic m, input logic d, output logic o);
		@(posedge clk);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (5) @(posedge clk);
		o = tdo;
		tck <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task automatic to_idle();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask

	// Scan from idle back to idle, least significant bit first
	task automatic scan(input logic ir, input int n, input logic [63:0] din);
		logic o;
		logic [63:0] got;
		got = '0;
		step(1'b1, 1'b1, o);
		if (ir)
			step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			got[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		dout <= got;
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ---- sim/bstap_bench.sv ----
// Self-checking bench for the boundary-scan access port.
`default_nettype none

module bstap_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import bstap_pkg::*;
	logic clk;
	logic reset;
	logic [47:0] pin_in;
	wire logic tck, tms, tdi, tdo, tdo_oe, done, test_mode, test_op_active;
	wire logic parallel_signature_op;
	wire logic [63:0] dout;
	wire logic [47:0] bsr_drive;
	wire logic [1:0] b_side_output_enable, a_side_output_enable_n;
	wire logic [2:0] test_op_code;
	wire logic [7:0] instruction;
	int failures, cmp_count, cyc, oe_cnt;
	int seed = 32'hee6d;
	logic [63:0] exp_q[$];
	logic [63:0] d;
	logic o;
	logic [47:0] pins;
	// Released TDO has no pull, so the master sees the inverse of the last bit
	wire logic tdo_line = tdo_oe ? tdo : ~tdo;
	logic [7:0] byp[2] = '{IR_BYPASS, 8'h3c};

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	bstap_top bstap_top_inst (
		.clk, .reset, .tck, .tms, .tdi, .tdo, .tdo_oe, .pin_in, .bsr_drive,
		.test_mode, .b_side_output_enable, .a_side_output_enable_n,
		.test_op_active, .test_op_code, .parallel_signature_op, .instruction
	);
	bstap_master bstap_master_inst (.clk, .tck, .tms, .tdi, .tdo(tdo_line), .done, .dout);

	////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] want);
		cmp_count++;
		if (seen !== want) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("failures %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	function automatic logic [63:0] rnd(input int n);
		return {$random(seed), $random(seed)} & ((64'h1 << n) - 64'h1);
	endfunction

	task automatic scan(input logic ir, input int n, input logic [63:0] din,
			input logic [63:0] want);
		int oe_start;
		oe_start = oe_cnt;
		exp_q.push_back(want);
		bstap_master_inst.scan(ir, n, din);
		// TDO is driven from the first shift fall to the exit fall, ten clocks a bit
		chk("drive cycles", 64'(oe_cnt - oe_start), 64'(10 * n));
	endtask

	// Load an opcode, then scan its data register with the current d
	task automatic dr(input logic [7:0] op, input int n, input logic [63:0] want);
		scan(1'b1, 8, 64'(op), 64'(IR_CAPTURE));
		chk("instruction", 64'(instruction), 64'(op));
		scan(1'b0, n, d, want);
	endtask

	always @(posedge clk) begin
		if (done)
			chk("scan out", dout, exp_q.pop_front());
	end

	always @(posedge clk) begin
		cyc++;
		if (tdo_oe === 1'b1)
			oe_cnt++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		pin_in = 48'(rnd(48));
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		chk("instruction", 64'(instruction), 64'(IR_RESET));
		chk("control", 64'(test_op_code), 64'(BCR_RESET));
		chk("enable cells", 64'(bsr_drive[47:44]), 64'h3);
		chk("test mode", 64'(test_mode), 64'h0);
		bstap_master_inst.to_idle();
		d = rnd(8);
		scan(1'b0, 40, d, 64'({d[7:0], ID_CODE_DEFAULT}));
		foreach (byp[i]) begin
			d = rnd(9);
			dr(byp[i], 9, 64'({d[7:0], 1'b0}));
		end
		pins = 48'(rnd(48));
		pin_in <= pins;
		d = rnd(48);
		dr(IR_SAMPLE, 48, 64'(pins));
		chk("latches", 64'(bsr_drive), d);
		chk("b enable", 64'(b_side_output_enable), 64'(pin_in[47:46]));
		chk("a enable", 64'(a_side_output_enable_n), 64'(pin_in[45:44]));
		d = rnd(48);
		dr(IR_EXTEST, 48, 64'(pin_in));
		chk("test mode", 64'(test_mode), 64'h1);
		chk("b enable", 64'(b_side_output_enable), 64'(d[47:46]));
		chk("a enable", 64'(a_side_output_enable_n), 64'(d[45:44]));
		d = rnd(48);
		dr(IR_RUNTEST, 48, 64'(pin_in));
		bstap_master_inst.step(1'b0, 1'b1, o);
		chk("op active", 64'(test_op_active), 64'h1);
		chk("signature", 64'(parallel_signature_op), 64'h1);
		bstap_master_inst.step(1'b1, 1'b1, o);
		bstap_master_inst.step(1'b1, 1'b1, o);
		chk("op active", 64'(test_op_active), 64'h0);
		bstap_master_inst.to_idle();
		d = 64'h5;
		dr(IR_BCRSCAN, 3, 64'(BCR_RESET));
		chk("control", 64'(test_op_code), 64'h5);
		bstap_master_inst.to_idle();
		chk("instruction", 64'(instruction), 64'(IR_RESET));
		chk("control", 64'(test_op_code), 64'(BCR_RESET));
		chk("test mode", 64'(test_mode), 64'h0);
		repeat (20) @(posedge clk);
		report_and_stop();
	end
endmodule

`default_nettype wire
